// [src/cbw_pkg.sv]
// Package with addresses, opcodes and widths for the cache boot wrapper
package cbw_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int DCR_ADDR_W = 10;
   localparam logic [31:0] INPUT_PORT_ADDR = 32'h01000000;
   localparam logic [9:0] FILL_REG_DCR_ADDR = 10'h3f1;
   localparam logic [31:0] VECTOR_TABLE_BASE = 32'hf0000000;
   localparam logic [31:0] VECTOR_TABLE_MASK = 32'hffff0000;
   localparam logic [31:0] TRAP_ADDR = 32'hffff3ff8;
   localparam logic [31:0] RESET_VECTOR = 32'hfffffffc;
   localparam logic [31:0] WRAP_ADDR = 32'h00000000;
   localparam logic [31:0] USER_ENTRY = 32'hffff3ffc;
   localparam logic [31:0] INSTR_BASE = 32'hffff0000;
   localparam logic [31:0] DATA_BASE = 32'hffff8000;
   localparam logic [31:0] CACHE_BYTES = 32'h00004000;
   localparam logic [31:0] FILL_RESET = 32'h00000000;
   // Absolute branch opcode, target in low 26 bits
   localparam logic [5:0] OP_BRANCH = 6'h12;
   localparam logic [1:0] BR_ABS = 2'h2;
   // Boot stub words placed on the on-chip instruction bus at 0x0
   localparam logic [31:0] BOOT_ICACHE_ON = 32'h7c00002c;
   localparam logic [31:0] BOOT_NOP = 32'h60000000;
   localparam int BOOT_WORDS = 4;
   localparam logic [3:0] RST_NOTIFY_CYCLES = 4'h8;
endpackage

// [src/cbw_fetch_if.sv]
// Interface carrying instruction fetch request and answer
`timescale 1ns/1ps
interface cbw_fetch_if;
   import cbw_pkg::*;
   logic req;
   logic [ADDR_W-1:0] addr;
   logic ack;
   logic [DATA_W-1:0] data;
   modport wrapper (output req, output addr, input ack, input data);
   modport rom (input req, input addr, output ack, output data);
endinterface

// [src/cbw_boot_rom.sv]
// Fixed instruction source for vector table, reset vector and boot stub
`timescale 1ns/1ps
module cbw_boot_rom
   import cbw_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Fetch port
   cbw_fetch_if.rom f
);
   logic ack;
   logic [DATA_W-1:0] data;
   logic next_ack;
   logic [DATA_W-1:0] next_data;

   // Absolute branch word
   function automatic logic [31:0] branch_to(input logic [31:0] target);
      branch_to = {OP_BRANCH, target[25:2], BR_ABS};
   endfunction

   // Word index inside the stub at address zero
   function automatic logic [31:0] stub_word(input logic [31:0] a);
      case (a[3:2])
         2'h0: stub_word = BOOT_ICACHE_ON;
         2'h1: stub_word = BOOT_NOP;
         2'h2: stub_word = branch_to(USER_ENTRY);
         default: stub_word = branch_to(USER_ENTRY);
      endcase
   endfunction

   // Decode; one-cycle answer for any fetch
   always_comb begin
      next_ack = f.req;
      next_data = data;
      if (f.req) begin
         if ((f.addr & VECTOR_TABLE_MASK) == VECTOR_TABLE_BASE) begin
            next_data = branch_to(TRAP_ADDR);
         end else if (f.addr == RESET_VECTOR) begin
            // Nop lets the counter roll over to zero
            next_data = BOOT_NOP;
         end else if (f.addr[31:4] == WRAP_ADDR[31:4]) begin
            next_data = stub_word(f.addr);
         end else begin
            next_data = BOOT_NOP;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ack <= 1'b0;
         data <= BOOT_NOP;
      end else begin
         ack <= next_ack;
         data <= next_data;
      end
   end

   assign f.ack = ack;
   assign f.data = data;
endmodule

// [src/cbw_top.sv]
// Boot and GPIO wrapper around a cache-only processor core
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module cbw_top
   import cbw_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Processor instruction fetch bus
   input wire logic i_fetch_req,
   input wire logic [ADDR_W-1:0] i_fetch_addr,
   output logic o_fetch_ack,
   output logic [DATA_W-1:0] o_fetch_data,
   // Data-side on-chip memory read bus
   input wire logic i_dsm_rd,
   input wire logic [ADDR_W-1:0] i_dsm_addr,
   output logic o_dsm_rd_ack,
   output logic [DATA_W-1:0] o_dsm_rd_data,
   // Device control bus write
   input wire logic i_dcr_wr,
   input wire logic [DCR_ADDR_W-1:0] i_dcr_addr,
   input wire logic [DATA_W-1:0] i_dcr_wdata,
   // Core reset request and debugger release
   input wire logic i_core_rst_req,
   input wire logic i_dbg_release,
   // Core control
   output logic o_core_halt,
   output logic o_core_reset,
   // User side
   input wire logic [DATA_W-1:0] i_gpio_in,
   output logic [DATA_W-1:0] o_gpio_out,
   input wire logic i_user_irq,
   output logic o_core_ext_irq,
   output logic o_system_reset_notify
);
   typedef enum logic [1:0] {
      CBW_HALTED = 2'b00,
      CBW_RUN = 2'b01,
      CBW_RESET = 2'b10
   } cbw_state_type;

   cbw_state_type state;
   cbw_state_type next_state;
   logic [3:0] rst_cnt;
   logic [3:0] next_rst_cnt;
   logic halt;
   logic next_halt;
   logic core_reset;
   logic next_core_reset;
   logic notify;
   logic next_notify;

   logic [DATA_W-1:0] gpio_in_s1;
   logic [DATA_W-1:0] gpio_in_s2;
   logic irq_s1;
   logic irq_s2;
   logic rel_s1;
   logic rel_s2;
   logic irq;
   logic next_irq;

   logic [DATA_W-1:0] instr_side_fill_reg;
   logic [DATA_W-1:0] next_fill;
   logic rd_ack;
   logic next_rd_ack;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] next_rd_data;

   cbw_fetch_if fetch ();

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Whole word is sampled each cycle; a word changing mid-sample may
   // tear, so user logic should hold it stable for a few cycles
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         gpio_in_s1 <= '0;
         gpio_in_s2 <= '0;
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
         rel_s1 <= 1'b0;
         rel_s2 <= 1'b0;
      end else begin
         gpio_in_s1 <= i_gpio_in;
         gpio_in_s2 <= gpio_in_s1;
         irq_s1 <= i_user_irq;
         irq_s2 <= irq_s1;
         rel_s1 <= i_dbg_release;
         rel_s2 <= rel_s1;
      end
   end

   // ****************************************************************
   // Halt and reset sequencing
   // ****************************************************************
   // Held halted from configuration; debugger release starts boot
   always_comb begin
      next_state = state;
      next_rst_cnt = rst_cnt;
      next_halt = halt;
      next_core_reset = 1'b0;
      next_notify = 1'b0;
      case (state)
         CBW_HALTED: begin
            next_halt = 1'b1;
            if (rel_s2) begin
               // Debugger takes over the test port from here
               next_halt = 1'b0;
               next_state = CBW_RUN;
            end
         end
         CBW_RUN: begin
            next_halt = 1'b0;
            if (i_core_rst_req) begin
               next_state = CBW_RESET;
               next_rst_cnt = RST_NOTIFY_CYCLES;
            end
         end
         CBW_RESET: begin
            // Core drops its caches and restarts at the reset vector
            next_core_reset = 1'b1;
            next_notify = 1'b1;
            next_rst_cnt = rst_cnt - 4'h1;
            if (rst_cnt == 4'h1) begin
               next_state = CBW_RUN;
            end
         end
         default: begin
            next_state = CBW_HALTED;
            next_halt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         state <= CBW_HALTED;
         rst_cnt <= 4'h0;
         halt <= 1'b1;
         core_reset <= 1'b1;
         notify <= 1'b1;
      end else begin
         state <= next_state;
         rst_cnt <= next_rst_cnt;
         halt <= next_halt;
         core_reset <= next_core_reset;
         notify <= next_notify;
      end
   end

   // ****************************************************************
   // GPIO and interrupt
   // ****************************************************************
   always_comb begin
      next_fill = instr_side_fill_reg;
      if (i_dcr_wr && i_dcr_addr == FILL_REG_DCR_ADDR) begin
         next_fill = i_dcr_wdata;
      end
      next_rd_ack = i_dsm_rd;
      next_rd_data = '0;
      if (i_dsm_rd && i_dsm_addr == INPUT_PORT_ADDR) begin
         next_rd_data = gpio_in_s2;
      end
      // Passed as a level, no edge capture
      next_irq = irq_s2;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         instr_side_fill_reg <= FILL_RESET;
         rd_ack <= 1'b0;
         rd_data <= '0;
         irq <= 1'b0;
      end else begin
         instr_side_fill_reg <= next_fill;
         rd_ack <= next_rd_ack;
         rd_data <= next_rd_data;
         irq <= next_irq;
      end
   end

   // ****************************************************************
   // Fixed instruction source
   // ****************************************************************
   assign fetch.req = i_fetch_req;
   assign fetch.addr = i_fetch_addr;

   cbw_boot_rom u_rom (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .f(fetch.rom)
   );

   assign o_fetch_ack = fetch.ack;
   assign o_fetch_data = fetch.data;
   assign o_dsm_rd_ack = rd_ack;
   assign o_dsm_rd_data = rd_data;
   assign o_core_halt = halt;
   assign o_core_reset = core_reset;
   assign o_gpio_out = instr_side_fill_reg;
   assign o_core_ext_irq = irq;
   assign o_system_reset_notify = notify;
endmodule

// [tb/cbw_checker.sv]
// Checker for fetch, GPIO, halt and reset behaviour of the wrapper
`timescale 1ns/1ps
module cbw_checker
   import cbw_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Buses from the core
   input wire logic i_fetch_req,
   input wire logic [ADDR_W-1:0] i_fetch_addr,
   input wire logic o_fetch_ack,
   input wire logic [DATA_W-1:0] o_fetch_data,
   input wire logic i_dsm_rd,
   input wire logic [ADDR_W-1:0] i_dsm_addr,
   input wire logic o_dsm_rd_ack,
   input wire logic [DATA_W-1:0] o_dsm_rd_data,
   input wire logic i_dcr_wr,
   input wire logic [DCR_ADDR_W-1:0] i_dcr_addr,
   input wire logic [DATA_W-1:0] i_dcr_wdata,
   // Core control and user side
   input wire logic i_core_rst_req,
   input wire logic i_dbg_release,
   input wire logic o_core_halt,
   input wire logic o_core_reset,
   input wire logic [DATA_W-1:0] i_gpio_in,
   input wire logic [DATA_W-1:0] o_gpio_out,
   input wire logic i_user_irq,
   input wire logic o_core_ext_irq,
   input wire logic o_system_reset_notify
);
   localparam logic [31:0] TRAP_BR = {OP_BRANCH, TRAP_ADDR[25:2], BR_ABS};
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   a_vector_trap_jump: assert property (
      i_fetch_req && i_fetch_addr[31:16] == 16'hf000
      |=> o_fetch_ack && o_fetch_data == TRAP_BR) else $error("bad trap");
   a_reset_vec_word: assert property (
      i_fetch_req && i_fetch_addr == RESET_VECTOR
      |=> o_fetch_data == BOOT_NOP) else $error("bad reset vector word");
   a_input_port_read: assert property (
      ((i_rstn && $stable(i_gpio_in))[*4] ##0
      (i_dsm_rd && i_dsm_addr == INPUT_PORT_ADDR)) |=> o_dsm_rd_ack &&
      o_dsm_rd_data == $past(i_gpio_in)) else $error("bad input read");
   a_fill_write: assert property (
      i_dcr_wr && i_dcr_addr == FILL_REG_DCR_ADDR
      |=> o_gpio_out == $past(i_dcr_wdata)) else $error("bad fill write");
   a_out_holds: assert property (
      !(i_dcr_wr && i_dcr_addr == FILL_REG_DCR_ADDR)
      |=> $stable(o_gpio_out)) else $error("output moved");
   a_reset_values: assert property (disable iff (1'b0)
      !i_rstn |=> o_gpio_out == 32'h0 && o_core_halt &&
      o_system_reset_notify) else $error("bad reset values");
   a_release_unhalt: assert property (
      $rose(i_dbg_release) |-> ##[1:4] !o_core_halt) else $error("no unhalt");
   a_core_reset_run: assert property (
      i_core_rst_req && !o_core_halt && !o_core_reset |-> ##2
      (o_core_reset && o_system_reset_notify)[*8] ##1 !o_core_reset)
      else $error("bad core reset pulse");
   a_irq_level_copy: assert property (
      i_rstn[*4] |-> o_core_ext_irq == $past(i_user_irq, 3))
      else $error("bad irq copy");
endmodule

// [tb/cbw_fabric_model.sv]
// Model of the user fabric and the test-port debugger
`timescale 1ns/1ps
module cbw_fabric_model (
   // Clock
   input wire logic i_sys_clk,
   // Commands from the bench
   input wire logic [31:0] i_word,
   input wire logic i_irq,
   input wire logic i_go,
   // Pins toward the wrapper
   output logic [31:0] o_gpio_in = 32'h0,
   output logic o_user_irq = 1'b0,
   output logic o_dbg_release = 1'b0
);
   // Fabric and debugger act just after the edge, as real logic would
   always @(posedge i_sys_clk) begin
      #1;
      o_gpio_in <= i_word;
      o_user_irq <= i_irq;
      // Debugger reaches the core through the test chain link
      o_dbg_release <= i_go;
   end
endmodule

// [tb/cbw_top_bench.sv]
// Self-checking bench for the cache boot wrapper
`timescale 1ns/1ps
module cbw_top_bench
   import cbw_pkg::*;
;
   localparam logic [31:0] TRAP_BR = {OP_BRANCH, TRAP_ADDR[25:2], BR_ABS};
   localparam logic [31:0] USER_BR = {OP_BRANCH, USER_ENTRY[25:2], BR_ABS};
   logic clk, fack, rack, halt, cres, xirq, ntf, rel;
   logic rstn = 1'b0, frq = 1'b0, rd = 1'b0, wr = 1'b0, crq = 1'b0;
   logic go = 1'b0, uirq = 1'b0, irq_w;
   logic [31:0] faddr = 32'h0, daddr = 32'h0, wdata = 32'h0, word = 32'h0;
   logic [31:0] fdata, ddata, gin, gout;
   logic [9:0] waddr = 10'h0;
   int fails = 0, check_count = 0, cyc = 0, n;
   cbw_top u_cbw_top (.i_sys_clk(clk), .i_rstn(rstn), .i_fetch_req(frq),
      .i_fetch_addr(faddr), .o_fetch_ack(fack), .o_fetch_data(fdata),
      .i_dsm_rd(rd), .i_dsm_addr(daddr), .o_dsm_rd_ack(rack),
      .o_dsm_rd_data(ddata), .i_dcr_wr(wr), .i_dcr_addr(waddr),
      .i_dcr_wdata(wdata), .i_core_rst_req(crq), .i_dbg_release(rel),
      .o_core_halt(halt), .o_core_reset(cres), .i_gpio_in(gin),
      .o_gpio_out(gout), .i_user_irq(irq_w), .o_core_ext_irq(xirq),
      .o_system_reset_notify(ntf));
   cbw_fabric_model u_cbw_fabric_model (.i_sys_clk(clk), .i_word(word),
      .i_irq(uirq), .i_go(go), .o_gpio_in(gin), .o_user_irq(irq_w),
      .o_dbg_release(rel));
   // Free running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard, far above the fewer than a hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   // Request stays up so successive calls run back to back
   task automatic fetch(input logic [31:0] a, input logic [31:0] e);
      frq = 1'b1;
      faddr = a;
      tick();
      check({31'h0, fack}, 32'h1);
      check(fdata, e);
   endtask
   task automatic dread(input logic [31:0] a, input logic [31:0] e);
      rd = 1'b1;
      daddr = a;
      tick();
      rd = 1'b0;
      check({31'h0, rack}, 32'h1);
      check(ddata, e);
      tick();
   endtask
   task automatic dwrite(input logic [9:0] a, input logic [31:0] d);
      wr = 1'b1;
      waddr = a;
      wdata = d;
      tick();
      wr = 1'b0;
      tick();
   endtask
   task automatic t_halted();
      repeat (5) tick();
      check({29'h0, halt, cres, ntf}, 32'h4);
      check(gout, 32'h0);
   endtask
   task automatic t_fetch();
      fetch(32'hf0000000, TRAP_BR);
      fetch(32'hf0000700, TRAP_BR);
      fetch(RESET_VECTOR, BOOT_NOP);
      fetch(32'h0, BOOT_ICACHE_ON);
      fetch(32'h8, USER_BR);
      fetch(32'hc, USER_BR);
      // Cache-resident code and data are never served from the buses
      fetch(INSTR_BASE + CACHE_BYTES - 32'h4, BOOT_NOP);
      fetch(DATA_BASE, BOOT_NOP);
      frq = 1'b0;
      tick();
   endtask
   task automatic t_gpio();
      word = 32'ha5c30f96;
      repeat (5) tick();
      dread(INPUT_PORT_ADDR, word);
      dread(INPUT_PORT_ADDR + 32'h4, 32'h0);
   endtask
   task automatic t_out();
      dwrite(FILL_REG_DCR_ADDR, 32'h12345678);
      check(gout, 32'h12345678);
      dwrite(10'h3f0, 32'hffffffff);
      check(gout, 32'h12345678);
   endtask
   task automatic t_irq();
      uirq = 1'b1;
      repeat (5) tick();
      check({31'h0, xirq}, 32'h1);
      uirq = 1'b0;
      repeat (5) tick();
      check({31'h0, xirq}, 32'h0);
   endtask
   // Debugger release must drop the halt within a few edges
   task automatic t_release();
      go = 1'b1;
      n = 0;
      while (halt !== 1'b0 && n < 10) begin
         tick();
         n++;
      end
      check({31'h0, halt}, 32'h0);
      // One edge in the model, then three edges in the wrapper
      check(n, 32'h4);
   endtask
   task automatic t_core_rst();
      crq = 1'b1;
      tick();
      crq = 1'b0;
      n = 0;
      repeat (14) begin
         tick();
         if (cres === 1'b1 && ntf === 1'b1) n++;
      end
      check(n, 32'h8);
      check({halt, cres}, 32'h0);
   endtask
   task automatic t_sys_rst();
      rstn = 1'b0;
      repeat (2) tick();
      check({29'h0, halt, cres, ntf}, 32'h7);
      check(gout, 32'h0);
      rstn = 1'b1;
      tick();
      check({29'h0, halt, cres, ntf}, 32'h4);
      fetch(RESET_VECTOR, BOOT_NOP);
      frq = 1'b0;
      tick();
   endtask
   task automatic print_verdict();
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      #2;
      rstn = 1'b1;
      t_halted();
      t_fetch();
      t_gpio();
      t_out();
      t_irq();
      t_release();
      t_core_rst();
      t_sys_rst();
      print_verdict();
   end
endmodule
bind cbw_top cbw_checker u_cbw_checker (.*);
